// *** sdcc_consts.vh ***
// Purpose: Constants for the serial-port diagnostics and checksum block
// Assumes: 25 MHz main clock; register addresses are 6-bit
// Notes: Definitions only
`ifndef SDCC_CONSTS_VH
`define SDCC_CONSTS_VH

// Clock and timing
`define SDCC_CLK_HZ 25000000
`define SDCC_MM_CHECK_RATE_HZ 300
`define SDCC_MM_CHECK_CYCLES (`SDCC_CLK_HZ / `SDCC_MM_CHECK_RATE_HZ)
`define SDCC_POR_WAIT_US 4
`define SDCC_POR_WAIT_CYCLES ((`SDCC_POR_WAIT_US * (`SDCC_CLK_HZ / 1000000)))

// Checksum
`define SDCC_CRC_POLY 8'h07
`define SDCC_CRC_INIT 8'h00
`define SDCC_STREAM_IMPLIED_CMD 8'h42
`define SDCC_STREAM_EXIT_CMD 8'h44

// Register addresses
`define SDCC_ADDR_STATUS 6'h00
`define SDCC_ADDR_CTRL 6'h01
`define SDCC_ADDR_DATA 6'h02
`define SDCC_ADDR_CFG 6'h03
`define SDCC_ADDR_CHAN 6'h04
`define SDCC_ADDR_ID 6'h05
`define SDCC_ADDR_ERR 6'h06
`define SDCC_ADDR_MISC 6'h07
`define SDCC_ADDR_LAST 6'h07

// Command byte fields
`define SDCC_CMD_RD_BIT 6

// Field positions
`define SDCC_CTRL_STREAM_BIT 8
`define SDCC_CFG_BURN_HI 7
`define SDCC_CFG_BURN_LO 6
`define SDCC_CHAN_POS_HI 9
`define SDCC_CHAN_POS_LO 5
`define SDCC_CHAN_NEG_HI 4
`define SDCC_CHAN_NEG_LO 0
`define SDCC_ERR_RD_BIT 0
`define SDCC_ERR_WR_BIT 1
`define SDCC_ERR_IGN_BIT 2
`define SDCC_ERR_CRC_BIT 3
`define SDCC_ERR_MM_BIT 4
`define SDCC_ERR_ROM_BIT 5

// Reset defaults held in the default ROM
`define SDCC_CTRL_RESET 24'h000000
`define SDCC_CFG_RESET 24'h000000
`define SDCC_CHAN_RESET 24'h000001
`define SDCC_MISC_RESET 24'h000000

`endif

// *** sdcc_top.v ***
// Purpose: Serial-port access checks, transfer checksums and register-map checksum
// Assumes: Host is SPI controller, mode 3, CS active low; pins sampled by clk_in
// Notes: One module holds all logic
`timescale 1ns/1ps
`include "sdcc_consts.vh"

module sdcc_top #(
  parameter MM_PERIOD = `SDCC_MM_CHECK_CYCLES,
  parameter POR_CYCLES = `SDCC_POR_WAIT_CYCLES,
  parameter [7:0] ID_VALUE = 8'h5a // Arbitrary identity value
) (
  // Clock and reset
  input wire clk_in,
  input wire reset_in,
  // Serial port pins
  input wire sclk_in,
  input wire cs_n_in,
  input wire mosi_in,
  output wire miso_out,
  output wire miso_oe_out,
  // Diagnostic enables
  input wire read_err_en_in,
  input wire write_err_en_in,
  input wire ignore_err_en_in,
  input wire crc_err_en_in,
  input wire regmap_checksum_enable_in,
  input wire rom_crc_en_in,
  input wire osc_diag_en_in,
  input wire standby_diag_control_in,
  // Converter state
  input wire calib_busy_in,
  input wire calib_done_in,
  input wire single_seq_busy_in,
  input wire seq_standby_done_in,
  input wire standby_in,
  input wire int_clk_sel_in,
  input wire [23:0] conv_data_in,
  // Error flags
  output wire read_err_out,
  output wire write_err_out,
  output wire ignore_err_out,
  output wire crc_err_out,
  output wire regmap_checksum_fail_flag_out,
  output wire rom_crc_err_out,
  // Configuration fields and status
  output wire [1:0] burnout_sel_out,
  output wire [4:0] positive_input_select_out,
  output wire [4:0] negative_input_select_out,
  output wire streaming_readout_enable_out,
  output wire regs_busy_out,
  output wire main_clk_keep_out,
  output wire osc_keep_out
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_CMD = 3'd1;
  localparam [2:0] ST_WDATA = 3'd2;
  localparam [2:0] ST_WCRC = 3'd3;
  localparam [2:0] ST_READ = 3'd4;
  localparam [2:0] ST_STREAM = 3'd5;

  // One checksum step over a byte, MSB first, zero start, no inversion
  function [7:0] crc8_byte;
    input [7:0] c;
    input [7:0] d;
    integer i;
    reg [7:0] r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (r[7] ^ d[7 - i])
          r = {r[6:0], 1'b0} ^ `SDCC_CRC_POLY;
        else
          r = {r[6:0], 1'b0};
      end
      crc8_byte = r;
    end
  endfunction

  // Checksum over the first n bytes of a left-justified word
  function [7:0] crc_seq;
    input [7:0] c;
    input [23:0] v;
    input [1:0] n;
    integer i;
    reg [7:0] r;
    begin
      r = c;
      for (i = 0; i < 3; i = i + 1) begin
        if (i < n)
          r = crc8_byte(r, v[23 - 8 * i -: 8]);
      end
      crc_seq = r;
    end
  endfunction

  // Checksum over the four writable registers only
  function [7:0] crc_map;
    input [95:0] m;
    integer j;
    reg [7:0] r;
    begin
      r = `SDCC_CRC_INIT;
      for (j = 0; j < 4; j = j + 1)
        r = crc_seq(r, m[95 - 24 * j -: 24], 2'd3);
      crc_map = r;
    end
  endfunction

  // Data bytes carried by each address
  function [1:0] reg_len;
    input [5:0] a;
    begin
      case (a)
        `SDCC_ADDR_CTRL: reg_len = 2'd2;
        `SDCC_ADDR_DATA: reg_len = 2'd3;
        `SDCC_ADDR_CFG: reg_len = 2'd2;
        `SDCC_ADDR_CHAN: reg_len = 2'd2;
        default: reg_len = 2'd1;
      endcase
    end
  endfunction

  // Storage index of a writable address; bit 2 set when not writable
  function [2:0] rw_idx;
    input [5:0] a;
    begin
      case (a)
        `SDCC_ADDR_CTRL: rw_idx = 3'd0;
        `SDCC_ADDR_CFG: rw_idx = 3'd1;
        `SDCC_ADDR_CHAN: rw_idx = 3'd2;
        `SDCC_ADDR_MISC: rw_idx = 3'd3;
        default: rw_idx = 3'd4;
      endcase
    end
  endfunction

  // Default ROM contents
  function [23:0] rom_word;
    input [1:0] k;
    begin
      case (k)
        2'd0: rom_word = `SDCC_CTRL_RESET;
        2'd1: rom_word = `SDCC_CFG_RESET;
        2'd2: rom_word = `SDCC_CHAN_RESET;
        default: rom_word = `SDCC_MISC_RESET;
      endcase
    end
  endfunction

  // Left-justified answer followed by its checksum
  function [31:0] frame32;
    input [23:0] v;
    input [1:0] n;
    input [7:0] c;
    begin
      case (n)
        2'd1: frame32 = {v[7:0], c, 16'h0000};
        2'd2: frame32 = {v[15:0], c, 8'h00};
        default: frame32 = {v, c};
      endcase
    end
  endfunction

  localparam [7:0] ROM_CRC_REF = crc_map({`SDCC_CTRL_RESET, `SDCC_CFG_RESET,
    `SDCC_CHAN_RESET, `SDCC_MISC_RESET});

  reg sclk_s1_q, sclk_s2_q, sclk_s3_q;
  reg cs_s1_q, cs_s2_q, cs_s3_q;
  reg mosi_s1_q, mosi_s2_q;
  reg [23:0] map_q [0:3];
  reg [2:0] st_q;
  reg [2:0] bit_q;
  reg [1:0] byte_q;
  reg [6:0] rx_q;
  reg [7:0] cmd_q;
  reg [23:0] wdata_q;
  reg [7:0] crc_q;
  reg [31:0] tx_q;
  reg miso_q, miso_oe_q;
  reg commit_q;
  reg load_q;
  reg [23:0] por_cnt_q;
  reg romchk_q;
  reg recalc_q;
  reg [7:0] mm_ref_q;
  reg [23:0] mm_tmr_q;
  reg rd_err_q, wr_err_q, ign_err_q, crc_err_q, mm_err_q, rom_err_q;
  reg busy_q, main_keep_q, osc_keep_q;
  reg [23:0] rd_val;

  wire sclk_rise = sclk_s2_q & ~sclk_s3_q;
  wire sclk_fall = ~sclk_s2_q & sclk_s3_q;
  wire cs_fall = ~cs_s2_q & cs_s3_q;
  wire [7:0] rx_byte = {rx_q, mosi_s2_q};
  wire byte_done = sclk_rise & (bit_q == 3'd7) & ~cs_s2_q;
  wire [5:0] rx_addr = rx_byte[5:0];
  wire [5:0] cmd_addr = cmd_q[5:0];
  wire [1:0] rx_len = reg_len(rx_addr);
  wire [1:0] cmd_len = reg_len(cmd_addr);
  wire [2:0] cmd_idx = rw_idx(cmd_addr);
  wire rx_mapped = (rx_addr <= `SDCC_ADDR_LAST);
  wire busy = load_q | calib_busy_in | single_seq_busy_in;
  wire [95:0] map_flat = {map_q[0], map_q[1], map_q[2], map_q[3]};
  wire [7:0] crc_now = crc_map(map_flat);
  wire streaming = map_q[0][`SDCC_CTRL_STREAM_BIT];
  wire [7:0] rd_seed = crc8_byte(`SDCC_CRC_INIT, rx_byte);
  wire [31:0] rd_frame = frame32(rd_val, rx_len, 8'h00);
  wire [7:0] rd_crc = crc_seq(rd_seed, rd_frame[31:8], rx_len);
  wire [7:0] st_seed = crc8_byte(`SDCC_CRC_INIT, `SDCC_STREAM_IMPLIED_CMD);
  wire [7:0] st_crc = crc_seq(st_seed, conv_data_in, 2'd3);
  wire [7:0] err_bits = {2'b00, rom_err_q, mm_err_q, crc_err_q, ign_err_q, wr_err_q, rd_err_q};

  // Read value for the addressed register; zeros while busy or unmapped
  always @* begin
    rd_val = 24'h000000;
    if (!busy) begin
      case (rx_addr)
        `SDCC_ADDR_STATUS: rd_val = {16'h0000, busy_q, 1'b0, err_bits[5:0]};
        `SDCC_ADDR_CTRL: rd_val = map_q[0];
        `SDCC_ADDR_DATA: rd_val = conv_data_in;
        `SDCC_ADDR_CFG: rd_val = map_q[1];
        `SDCC_ADDR_CHAN: rd_val = map_q[2];
        `SDCC_ADDR_ID: rd_val = {16'h0000, ID_VALUE};
        `SDCC_ADDR_ERR: rd_val = {16'h0000, err_bits};
        `SDCC_ADDR_MISC: rd_val = map_q[3];
        default: rd_val = 24'h000000;
      endcase
    end
  end

  // Two-stage synchronisers for the serial pins, third stage for edges
  always @(posedge clk_in) begin
    if (reset_in) begin
      sclk_s1_q <= 1'b1;
      sclk_s2_q <= 1'b1;
      sclk_s3_q <= 1'b1;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
    end else begin
      sclk_s1_q <= sclk_in;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q <= cs_n_in;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      mosi_s1_q <= mosi_in;
      mosi_s2_q <= mosi_s1_q;
    end
  end

  // Frame engine, register map, checks and flags
  always @(posedge clk_in) begin
    if (reset_in) begin
      st_q <= ST_IDLE;
      bit_q <= 3'd0;
      byte_q <= 2'd0;
      rx_q <= 7'h00;
      cmd_q <= 8'h00;
      wdata_q <= 24'h000000;
      crc_q <= 8'h00;
      tx_q <= 32'h00000000;
      map_q[0] <= 24'h000000; // Known values until defaults load
      map_q[1] <= 24'h000000;
      map_q[2] <= 24'h000000;
      map_q[3] <= 24'h000000;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
      commit_q <= 1'b0;
      load_q <= 1'b1;
      por_cnt_q <= 24'h000000;
      romchk_q <= 1'b0;
      recalc_q <= 1'b0;
      mm_ref_q <= 8'h00;
      mm_tmr_q <= 24'h000000;
      rd_err_q <= 1'b0;
      wr_err_q <= 1'b0;
      ign_err_q <= 1'b0;
      crc_err_q <= 1'b0;
      mm_err_q <= 1'b0;
      rom_err_q <= 1'b0;
      busy_q <= 1'b1;
      main_keep_q <= 1'b0;
      osc_keep_q <= 1'b0;
    end else begin
      commit_q <= 1'b0;
      romchk_q <= 1'b0;
      recalc_q <= 1'b0;
      busy_q <= busy;
      main_keep_q <= standby_in & rom_crc_en_in & int_clk_sel_in;
      osc_keep_q <= standby_in & standby_diag_control_in & osc_diag_en_in;
      // Default loading from ROM after reset
      if (load_q) begin
        if (por_cnt_q < 24'd4)
          map_q[por_cnt_q[1:0]] <= rom_word(por_cnt_q[1:0]);
        if (por_cnt_q == POR_CYCLES[23:0] - 24'd1) begin
          load_q <= 1'b0;
          romchk_q <= 1'b1;
        end
        por_cnt_q <= por_cnt_q + 24'd1;
      end
      // Frame start, bit shifting and answer driving
      if (cs_s2_q) begin
        st_q <= ST_IDLE;
        bit_q <= 3'd0;
        miso_oe_q <= 1'b0;
      end else begin
        miso_oe_q <= 1'b1;
        if (cs_fall) begin
          byte_q <= 2'd0;
          if (streaming && !busy) begin
            st_q <= ST_STREAM;
            miso_q <= 1'b0;
            tx_q <= {conv_data_in, st_crc};
          end else begin
            st_q <= ST_CMD;
            tx_q <= 32'h00000000;
            miso_q <= 1'b0;
          end
        end
        if (sclk_rise) begin
          rx_q <= rx_byte[6:0];
          bit_q <= bit_q + 3'd1;
        end
        if (sclk_fall) begin
          miso_q <= tx_q[31];
          tx_q <= {tx_q[30:0], 1'b0};
        end
      end
      // Completed byte handling
      if (byte_done) begin
        case (st_q)
          ST_CMD: begin
            cmd_q <= rx_byte;
            byte_q <= 2'd0;
            if (rx_byte[`SDCC_CMD_RD_BIT]) begin
              st_q <= ST_READ;
              if (crc_err_en_in)
                tx_q <= frame32(rd_val, rx_len, rd_crc);
              else
                tx_q <= frame32(rd_val, rx_len, 8'h00);
              if (!rx_mapped && read_err_en_in)
                rd_err_q <= 1'b1;
            end else begin
              st_q <= ST_WDATA;
              crc_q <= rd_seed;
              wdata_q <= 24'h000000;
            end
          end
          ST_WDATA: begin
            wdata_q <= {wdata_q[15:0], rx_byte};
            crc_q <= crc8_byte(crc_q, rx_byte);
            byte_q <= byte_q + 2'd1;
            if (byte_q == cmd_len - 2'd1) begin
              if (crc_err_en_in) begin
                st_q <= ST_WCRC;
              end else begin
                st_q <= ST_READ;
                commit_q <= 1'b1;
              end
            end
          end
          ST_WCRC: begin
            st_q <= ST_READ;
            if (rx_byte == crc_q)
              commit_q <= 1'b1;
            else
              crc_err_q <= 1'b1;
          end
          ST_STREAM: begin
            st_q <= ST_READ;
            if (rx_byte == `SDCC_STREAM_EXIT_CMD) begin
              map_q[0][`SDCC_CTRL_STREAM_BIT] <= 1'b0;
              recalc_q <= 1'b1;
            end
          end
          default: st_q <= ST_READ;
        endcase
      end
      // Write commit after all checks
      if (commit_q) begin
        if (cmd_addr == `SDCC_ADDR_ERR) begin
          rd_err_q <= rd_err_q & ~wdata_q[`SDCC_ERR_RD_BIT];
          wr_err_q <= wr_err_q & ~wdata_q[`SDCC_ERR_WR_BIT];
          ign_err_q <= ign_err_q & ~wdata_q[`SDCC_ERR_IGN_BIT];
          crc_err_q <= crc_err_q & ~wdata_q[`SDCC_ERR_CRC_BIT];
          mm_err_q <= mm_err_q & ~wdata_q[`SDCC_ERR_MM_BIT];
          rom_err_q <= rom_err_q & ~wdata_q[`SDCC_ERR_ROM_BIT];
        end else if (ign_err_q || busy) begin
          cmd_q <= cmd_q;
        end else if (cmd_idx[2]) begin
          if (write_err_en_in)
            wr_err_q <= 1'b1;
        end else begin
          case (cmd_len)
            2'd1: map_q[cmd_idx[1:0]] <= {16'h0000, wdata_q[7:0]};
            2'd2: map_q[cmd_idx[1:0]] <= {8'h00, wdata_q[15:0]};
            default: map_q[cmd_idx[1:0]] <= wdata_q;
          endcase
          recalc_q <= 1'b1;
        end
      end
      // Stored map checksum refresh on events
      if (calib_done_in || seq_standby_done_in)
        recalc_q <= 1'b1;
      if (recalc_q || romchk_q)
        mm_ref_q <= crc_now;
      // Default ROM check once loading ends
      if (romchk_q && rom_crc_en_in && crc_now != ROM_CRC_REF)
        rom_err_q <= 1'b1;
      // Periodic map check
      if (mm_tmr_q == MM_PERIOD[23:0] - 24'd1) begin
        mm_tmr_q <= 24'h000000;
        if (regmap_checksum_enable_in && !load_q && !recalc_q && !romchk_q && crc_now != mm_ref_q)
          mm_err_q <= 1'b1;
      end else begin
        mm_tmr_q <= mm_tmr_q + 24'd1;
      end
      // Busy-ignore flag; set wins over a same-cycle clear
      if (busy && ignore_err_en_in)
        ign_err_q <= 1'b1;
    end
  end

  // Output fields straight from flip-flops
  assign miso_out = miso_q;
  assign miso_oe_out = miso_oe_q;
  assign read_err_out = rd_err_q;
  assign write_err_out = wr_err_q;
  assign ignore_err_out = ign_err_q;
  assign crc_err_out = crc_err_q;
  assign regmap_checksum_fail_flag_out = mm_err_q;
  assign rom_crc_err_out = rom_err_q;
  assign burnout_sel_out = map_q[1][`SDCC_CFG_BURN_HI:`SDCC_CFG_BURN_LO];
  assign positive_input_select_out = map_q[2][`SDCC_CHAN_POS_HI:`SDCC_CHAN_POS_LO];
  assign negative_input_select_out = map_q[2][`SDCC_CHAN_NEG_HI:`SDCC_CHAN_NEG_LO];
  assign streaming_readout_enable_out = streaming;
  assign regs_busy_out = busy_q;
  assign main_clk_keep_out = main_keep_q;
  assign osc_keep_out = osc_keep_q;

endmodule

// *** sdcc_top_asserts.sv ***
// Purpose: Port assertions for the diagnostics and checksum block
// Assumes: One clock domain; reset_in synchronous, active high
// Notes: Bound into sdcc_top below the module
`timescale 1ns/1ps
module sdcc_chk (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Inputs watched
  input wire logic cs_n_in,
  input wire logic ignore_err_en_in,
  input wire logic regmap_checksum_enable_in,
  input wire logic rom_crc_en_in,
  input wire logic osc_diag_en_in,
  input wire logic standby_diag_control_in,
  input wire logic calib_busy_in,
  input wire logic single_seq_busy_in,
  input wire logic standby_in,
  input wire logic int_clk_sel_in,
  // Outputs watched
  input wire logic ignore_err_out,
  input wire logic crc_err_out,
  input wire logic write_err_out,
  input wire logic regmap_checksum_fail_flag_out,
  input wire logic rom_crc_err_out,
  input wire logic [1:0] burnout_sel_out,
  input wire logic regs_busy_out,
  input wire logic main_clk_keep_out,
  input wire logic osc_keep_out
);
  // All checks on the main clock, off during reset
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  AST_BUSY_CAL: assert property (calib_busy_in |-> ##[1:2] regs_busy_out)
    else $error("registers not busy during calibration");
  AST_BUSY_SEQ: assert property (single_seq_busy_in |-> ##[1:2] regs_busy_out)
    else $error("registers not busy during single sequence");
  AST_IGN_SET: assert property (regs_busy_out && ignore_err_en_in |-> ##[0:3] ignore_err_out)
    else $error("ignore flag not raised while busy");
  AST_FLAG_HOLD: assert property ((cs_n_in && $past(cs_n_in, 4)) |->
      !$fell(ignore_err_out) && !$fell(crc_err_out) && !$fell(write_err_out))
    else $error("error flag cleared without a host write");
  AST_CFG_FROZEN: assert property (regs_busy_out && $past(regs_busy_out) |->
      $stable(burnout_sel_out))
    else $error("configuration changed while busy");
  AST_MAP_OFF: assert property (!regmap_checksum_enable_in &&
      !regmap_checksum_fail_flag_out |=> !regmap_checksum_fail_flag_out)
    else $error("map checksum flag set while check disabled");
  AST_ROM_OFF: assert property (!rom_crc_en_in && !rom_crc_err_out |=> !rom_crc_err_out)
    else $error("ROM checksum flag set while check disabled");
  AST_MAIN_KEEP: assert property (standby_in && rom_crc_en_in && int_clk_sel_in |=>
      main_clk_keep_out)
    else $error("main clock not kept in standby");
  AST_OSC_KEEP: assert property (standby_in && standby_diag_control_in && osc_diag_en_in
      |=> osc_keep_out)
    else $error("oscillator not kept in standby");
  AST_OSC_OFF: assert property (!standby_in |=> !osc_keep_out)
    else $error("oscillator kept outside standby");
endmodule

bind sdcc_top sdcc_chk u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .cs_n_in(cs_n_in),
  .ignore_err_en_in(ignore_err_en_in), .regmap_checksum_enable_in(regmap_checksum_enable_in),
  .rom_crc_en_in(rom_crc_en_in), .osc_diag_en_in(osc_diag_en_in),
  .standby_diag_control_in(standby_diag_control_in), .calib_busy_in(calib_busy_in),
  .single_seq_busy_in(single_seq_busy_in), .standby_in(standby_in),
  .int_clk_sel_in(int_clk_sel_in), .ignore_err_out(ignore_err_out),
  .crc_err_out(crc_err_out), .write_err_out(write_err_out),
  .regmap_checksum_fail_flag_out(regmap_checksum_fail_flag_out),
  .rom_crc_err_out(rom_crc_err_out), .burnout_sel_out(burnout_sel_out),
  .regs_busy_out(regs_busy_out), .main_clk_keep_out(main_clk_keep_out),
  .osc_keep_out(osc_keep_out)
);

// *** sdcc_host.sv ***
// Purpose: Serial controller model standing in for the host
// Assumes: Mode 3 framing, clock idle high, eight main-clock cycles a bit
// Notes: Bit times counted on falling main-clock edges
`timescale 1ns/1ps
module sdcc_host (
  // Timing reference
  input wire logic clk_in,
  // Serial pins
  input wire logic miso_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out
);
  // Idle pins: clock and select high
  initial begin
    sclk_out = 1'b1;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // One framed transfer of n bytes, MSB first, sampling just before each fall
  task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx);
    rx = 64'h0;
    @(negedge clk_in);
    cs_n_out = 1'b0;
    repeat (4) @(negedge clk_in);
    for (int i = n * 8 - 1; i >= 0; i--) begin
      sclk_out = 1'b0;
      mosi_out = tx[i];
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (3) @(negedge clk_in);
      rx = {rx[62:0], miso_in};
      repeat (1) @(negedge clk_in);
    end
    repeat (5) @(negedge clk_in);
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out; // Released line shows no stale bit
    repeat (8) @(negedge clk_in);
  endtask
endmodule

// *** sdcc_top_tb.sv ***
// Purpose: Self-checking bench for the diagnostics and checksum block
// Assumes: 25 MHz clock; host model frames all serial traffic
// Notes: Short map-check period; loading long enough to hold one frame
`timescale 1ns/1ps
module sdcc_top_tb;
  localparam int MMP = 200;
  localparam int PORC = 400;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic map_en = 1'b0;
  logic wen = 1'b1;
  logic rom_en = 1'b1;
  logic osc_en = 1'b0;
  logic stb_diag = 1'b0;
  logic cal_busy = 1'b0;
  logic cal_done = 1'b0;
  logic seq_busy = 1'b0;
  logic seq_done = 1'b0;
  logic stby = 1'b0;
  logic iclk = 1'b0;
  logic [23:0] conv = 24'h000000;
  wire sclk, cs_n, mosi, miso;
  wire rd_err, wr_err, ign_err, crc_err, map_err, rom_err;
  wire [1:0] burn;
  wire [4:0] psel;
  wire [4:0] nsel;
  wire strm, busy, mkeep, okeep, oe;
  int errors = 0;
  int checked = 0;

  // Main clock
  always #20 clk_in = ~clk_in;

  sdcc_host host (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk), .cs_n_out(cs_n),
    .mosi_out(mosi));

  sdcc_top #(.MM_PERIOD(MMP), .POR_CYCLES(PORC)) dut (
    .clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi),
    .miso_out(miso), .miso_oe_out(oe), .read_err_en_in(1'b1), .write_err_en_in(wen),
    .ignore_err_en_in(1'b1), .crc_err_en_in(1'b1), .regmap_checksum_enable_in(map_en),
    .rom_crc_en_in(rom_en), .osc_diag_en_in(osc_en), .standby_diag_control_in(stb_diag),
    .calib_busy_in(cal_busy), .calib_done_in(cal_done), .single_seq_busy_in(seq_busy),
    .seq_standby_done_in(seq_done), .standby_in(stby), .int_clk_sel_in(iclk),
    .conv_data_in(conv), .read_err_out(rd_err), .write_err_out(wr_err),
    .ignore_err_out(ign_err), .crc_err_out(crc_err), .regmap_checksum_fail_flag_out(map_err),
    .rom_crc_err_out(rom_err), .burnout_sel_out(burn), .positive_input_select_out(psel),
    .negative_input_select_out(nsel), .streaming_readout_enable_out(strm),
    .regs_busy_out(busy), .main_clk_keep_out(mkeep), .osc_keep_out(okeep));

  // Verdict and end of run
  task automatic close_out();
    $display("Checks %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bitwise CRC-8, poly 0x07, zero start, MSB first
  function automatic logic [7:0] crc8(input logic [63:0] m, input int nb);
    logic [7:0] c;
    c = 8'h00;
    for (int i = nb * 8 - 1; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  // Write frame: command, data, checksum (bad flips checksum bits)
  task automatic wr(input logic [5:0] a, input int nb, input logic [23:0] d,
    input logic [7:0] bad);
    logic [63:0] msg;
    logic [63:0] rx;
    msg = ({58'h0, a} << (nb * 8)) | {40'h0, d};
    host.xfer(nb + 2, {msg[55:0], crc8(msg, nb + 1) ^ bad}, rx);
    repeat (4) @(negedge clk_in);
  endtask

  // Read frame; judges data and device checksum
  task automatic rd(input logic [5:0] a, input int nb, input logic [31:0] exp, input string what);
    logic [63:0] rx;
    logic [63:0] cmd;
    cmd = {56'h0, 2'b01, a};
    host.xfer(nb + 2, cmd << ((nb + 1) * 8), rx);
    chk(what, rx[39:8] & ~(32'hffffffff << (nb * 8)), exp);
    chk("read checksum", {24'h0, rx[7:0]}, {24'h0, crc8((cmd << (nb * 8)) | exp, nb + 1)});
  endtask

  // Clear every error flag
  task automatic clear_flags();
    wr(6'h06, 1, 24'h00003f, 8'h00);
  endtask

  // Bounded wait for the end of register busy
  task automatic wait_ready();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 1000) begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 1000) begin
      errors++;
      close_out();
    end
  endtask

  // Access during default loading is refused and flagged
  task automatic t_power_up();
    chk("busy at start", busy, 1'b1);
    wr(6'h03, 2, 24'h000080, 8'h00);
    chk("burnout after early write", burn, 2'b00);
    wait_ready();
    chk("ignore flag after loading", ign_err, 1'b1);
    wr(6'h03, 2, 24'h000080, 8'h00);
    chk("burnout with ignore set", burn, 2'b00);
    clear_flags();
    chk("ignore flag cleared", ign_err, 1'b0);
    chk("ROM flag", rom_err, 1'b0);
    chk("output enable idle", oe, 1'b0);
  endtask

  // Burnout codes and input selects, read back with checksum
  task automatic t_fields();
    for (int b = 0; b < 4; b++) begin
      wr(6'h03, 2, {16'h0, b[1:0], 6'h00}, 8'h00);
      chk("burnout code", burn, b[1:0]);
      rd(6'h03, 2, {24'h0, b[1:0], 6'h00}, "config readback");
    end
    wr(6'h04, 2, 24'h000233, 8'h00);
    chk("positive select", psel, 5'h11);
    chk("negative select", nsel, 5'h13);
    rd(6'h04, 2, 32'h00000233, "channel readback");
  endtask

  // Unmapped read, read-only and unmapped writes, bad checksum
  task automatic t_refusals();
    logic [5:0] ro [3];
    ro = '{6'h00, 6'h05, 6'h30};
    rd(6'h20, 1, 32'h0, "unmapped read data");
    chk("read error flag", rd_err, 1'b1);
    for (int j = 0; j < 3; j++) begin
      clear_flags();
      wr(ro[j], 1, 24'h0000a5, 8'h00);
      chk("write error flag", wr_err, 1'b1);
    end
    clear_flags();
    wen = 1'b0;
    wr(6'h05, 1, 24'h0000a5, 8'h00);
    chk("write error flag disabled", wr_err, 1'b0);
    wen = 1'b1;
    wr(6'h03, 2, 24'h000040, 8'h01);
    chk("checksum flag", crc_err, 1'b1);
    chk("burnout after bad checksum", burn, 2'b11);
    clear_flags();
    chk("checksum flag cleared", crc_err, 1'b0);
  endtask

  // Calibration and single sequence block access
  task automatic t_busy();
    for (int j = 0; j < 2; j++) begin
      cal_busy = (j == 0);
      seq_busy = (j == 1);
      repeat (3) @(negedge clk_in);
      chk("busy flag", busy, 1'b1);
      wr(6'h03, 2, 24'h000000, 8'h00);
      chk("burnout while busy", burn, 2'b11);
      chk("ignore flag while busy", ign_err, 1'b1);
      rd(6'h03, 2, 32'h0, "read while busy");
      cal_busy = 1'b0;
      seq_busy = 1'b0;
      wait_ready();
      clear_flags();
      chk("ignore flag after busy", ign_err, 1'b0);
    end
  endtask

  // Streaming frames, including all-zero data, then exit
  task automatic t_stream_frame(input logic [23:0] v);
    logic [63:0] rx;
    conv = v;
    host.xfer(4, 64'h0, rx);
    chk("stream data", {8'h0, rx[31:8]}, {8'h0, v});
    chk("stream checksum", {24'h0, rx[7:0]}, {24'h0, crc8({32'h0, 8'h42, v}, 4)});
  endtask

  task automatic t_stream();
    logic [63:0] rx;
    wr(6'h01, 2, 24'h000100, 8'h00);
    chk("streaming on", strm, 1'b1);
    t_stream_frame(24'h000000);
    t_stream_frame(24'ha5c3e1);
    host.xfer(4, 64'h44000000, rx);
    repeat (4) @(negedge clk_in);
    chk("streaming off", strm, 1'b0);
  endtask

  // Map check across recompute events and several periods
  task automatic t_map();
    map_en = 1'b1;
    @(negedge clk_in);
    cal_done = 1'b1;
    @(negedge clk_in);
    cal_done = 1'b0;
    seq_done = 1'b1;
    @(negedge clk_in);
    seq_done = 1'b0;
    wr(6'h07, 1, 24'h000001, 8'h00);
    repeat (2 * MMP + 10) @(negedge clk_in);
    chk("map checksum flag", map_err, 1'b0);
    wr(6'h03, 2, 24'h000040, 8'h00);
    repeat (2 * MMP + 10) @(negedge clk_in);
    chk("map flag after write", map_err, 1'b0);
  endtask

  // Standby clock keeping over 16 input combinations, with int_clk_sel_in tied to osc_diag_en_in
  task automatic t_keep();
    for (int i = 0; i < 16; i++) begin
      stby = i[0];
      rom_en = i[1];
      iclk = i[2];
      osc_en = i[2];
      stb_diag = i[3];
      repeat (2) @(negedge clk_in);
      chk("main clock keep", mkeep, i[0] & i[1] & i[2]);
      chk("oscillator keep", okeep, i[0] & i[2] & i[3]);
    end
  endtask

  // Main sequence
  initial begin
    repeat (6) @(negedge clk_in);
    reset_in = 1'b0;
    t_power_up();
    t_fields();
    t_refusals();
    t_busy();
    t_stream();
    t_map();
    t_keep();
    close_out();
  end
endmodule
